// ---- hw/sfr_defs.svh ----
// constants for the speed dependent flow ramp limiter
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

`define SFR_CLK_KHZ 25000
`define SFR_TICK_MS 1
`define SFR_TICK_CYCLES (`SFR_CLK_KHZ * `SFR_TICK_MS)

`define SFR_FULL_SCALE 10'h3e8
`define SFR_FRAC_ONE 11'h400
`define SFR_DIV_STEPS 5'h14

`define SFR_MODE_OFF 2'h0
`define SFR_MODE_FIXED 2'h1
`define SFR_MODE_SPEED 2'h2

`define SFR_BREAK_1 10'h032
`define SFR_BREAK_2 10'h078
`define SFR_BREAK_3 10'h14d

`define SFR_DEF_MODE 2'h0
`define SFR_DEF_SHAPE 4'h0
`define SFR_DEF_RISE_MS 10'h0c8
`define SFR_DEF_FALL_MS 10'h15e
`define SFR_DEF_SPAN 10'h1f4
`define SFR_DEF_FAST_THR 10'h3e8
`define SFR_DEF_FAST_MS 10'h064
`define SFR_DEF_ABORT_THR 10'h000
`define SFR_DEF_ABORT_MS 10'h001

`endif

// ---- hw/sfr_pkg.sv ----
// types and helpers for the speed dependent flow ramp limiter
package sfr_pkg;

  // sign-magnitude flow word, 0.1 % of full port flow per unit
  typedef struct packed {
    logic neg;
    logic [9:0] mag;
  } sfr_flow_s;

  typedef struct packed {
    logic [1:0] ramp_type_select;
    logic [3:0] rise_curve_shape;
    logic [3:0] fall_curve_shape;
    logic [9:0] rise_ms_zero;
    logic [9:0] fall_ms_zero;
    logic [9:0] rise_ms_top;
    logic [9:0] fall_ms_top;
    logic [9:0] speed_span;
    logic [9:0] fast_fall_threshold;
    logic [9:0] fast_fall_ms;
    logic [9:0] reverse_abort_threshold;
    logic [9:0] abort_fall_ms;
  } sfr_cfg_s;

  typedef enum logic [4:0] {
    SFR_HOLD = 5'h01,
    SFR_RISE = 5'h02,
    SFR_FAST = 5'h04,
    SFR_SLOW = 5'h08,
    SFR_ABORT = 5'h10
  } sfr_phase_e;

  function automatic logic signed [11:0] sfr_to_s(input sfr_flow_s f);
    sfr_to_s = f.neg ? -$signed({2'b00, f.mag}) : $signed({2'b00, f.mag});
  endfunction : sfr_to_s

  function automatic sfr_flow_s sfr_to_flow(input logic signed [11:0] v);
    logic [11:0] a;
    a = v[11] ? 12'(-v) : 12'(v);
    sfr_to_flow.neg = v[11];
    sfr_to_flow.mag = a[9:0];
  endfunction : sfr_to_flow

endpackage : sfr_pkg

// ---- hw/sfr_ramp_limiter.sv ----
// request fifo and anti-jerk flow ramp limiter
`timescale 1ns/10ps
`include "sfr_defs.svh"

module sfr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic not_full_r;
  logic not_empty_r;

  wire push = in_valid & not_full_r;
  wire pop = not_empty_r & out_ready;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready = not_full_r;
  assign out_valid = not_empty_r;
  assign out_data = mem[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      not_full_r <= 1'b1;
      not_empty_r <= 1'b0;
    end else begin
      wp_r <= push ? wp_r + 1'b1 : wp_r;
      rp_r <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_nxt;
      not_full_r <= cnt_nxt != (AW+1)'(DEPTH);
      not_empty_r <= cnt_nxt != '0;
    end
  end
endmodule : sfr_fifo

module sfr_ramp_limiter
  import sfr_pkg::*;
#(
  parameter int TICK_CYCLES = `SFR_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire sfr_cfg_s cfg,
  input wire logic [11:0] vehicle_speed,
  input wire sfr_flow_s req_flow,
  input wire logic req_valid,
  output logic req_ready_r,
  output sfr_flow_s cmd_flow_r,
  output logic cmd_valid_r,
  output sfr_phase_e phase_r
);

  // interpolation: t0 plus or minus share of the difference toward th, frac of 1024
  function automatic logic [9:0] sfr_interp(input logic [9:0] t0,
                                            input logic [9:0] th,
                                            input logic [10:0] frac);
    logic [9:0] d;
    logic [20:0] p;
    d = (th >= t0) ? th - t0 : t0 - th;
    p = 21'(d) * 21'(frac);
    sfr_interp = (th >= t0) ? t0 + p[19:10] : t0 - p[19:10];
  endfunction : sfr_interp

  // progressive curve: time stretched near zero flow, per segment
  function automatic logic [12:0] sfr_shape(input logic [9:0] t,
                                            input logic [3:0] s,
                                            input logic [9:0] mag);
    logic [3:0] sc;
    logic [13:0] ext;
    sc = (s > 4'ha) ? 4'ha : s;
    ext = 14'(t) * 14'(sc);
    if (mag < `SFR_BREAK_1) begin
      sfr_shape = 13'(t) + ext[13:1];
    end else if (mag < `SFR_BREAK_2) begin
      sfr_shape = 13'(t) + 13'(ext[13:2]);
    end else if (mag < `SFR_BREAK_3) begin
      sfr_shape = 13'(t) + 13'(ext[13:3]);
    end else begin
      sfr_shape = 13'(t);
    end
  endfunction : sfr_shape

  logic [15:0] tick_cnt_r;
  logic signed [11:0] tgt_r;
  logic [13:0] acc_r;
  logic abort_r;
  logic [10:0] frac_r;
  logic [4:0] div_cnt_r;
  logic [19:0] div_nq_r;
  logic [10:0] div_rem_r;
  logic fifo_ready;
  logic fifo_valid;
  logic [10:0] fifo_data;

  // tick pacing: the fifo drains one word per tick, so the source
  // sees real back-pressure if it sends faster than the ramp consumes
  wire tick = tick_cnt_r == 16'(TICK_CYCLES - 1);
  wire pop = tick & fifo_valid;
  wire signed [11:0] new_tgt = sfr_to_s(fifo_data);
  wire signed [11:0] tgt_now = pop ? new_tgt : tgt_r;

  sfr_fifo #(
    .WIDTH(11),
    .DEPTH(16)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(req_valid),
    .in_ready(fifo_ready),
    .in_data(req_flow),
    .out_valid(fifo_valid),
    .out_ready(tick),
    .out_data(fifo_data)
  );

  // speed share of the span, divided serially once per tick
  wire [9:0] speed_clamped = (vehicle_speed >= 12'(cfg.speed_span)) ?
                             cfg.speed_span : vehicle_speed[9:0];
  wire [10:0] rem_sh = {div_rem_r[9:0], div_nq_r[19]};
  wire div_ge = rem_sh >= {1'b0, cfg.speed_span};
  wire [10:0] rem_sub = rem_sh - {1'b0, cfg.speed_span};
  wire div_busy = div_cnt_r != 5'h00;
  wire div_last = div_cnt_r == 5'h01;
  wire [19:0] nq_nxt = {div_nq_r[18:0], div_ge};

  // fixed mode keeps the zero-speed times
  wire speed_mode = cfg.ramp_type_select == `SFR_MODE_SPEED;
  wire ramp_on = speed_mode ||
                 cfg.ramp_type_select == `SFR_MODE_FIXED;
  wire [10:0] frac_use = speed_mode ? frac_r : 11'h000;

  // direction of travel relative to zero
  wire signed [11:0] out_s = sfr_to_s(cmd_flow_r);
  wire [9:0] out_mag = cmd_flow_r.mag;
  // named wire: some front ends refuse a member select on a call
  wire sfr_flow_s tgt_flow = sfr_to_flow(tgt_now);
  wire [9:0] tgt_mag = tgt_flow.mag;
  wire moving = tgt_now != out_s;
  wire toward_zero = (out_s > 0 && tgt_now < out_s) ||
                     (out_s < 0 && tgt_now > out_s);
  wire reverse = (out_s > 0 && tgt_now < 0) ||
                 (out_s < 0 && tgt_now > 0);

  // fast range sits above the threshold, measured on the set-point
  wire fast_en = cfg.fast_fall_threshold < `SFR_FULL_SCALE;
  wire in_fast = fast_en && out_mag > cfg.fast_fall_threshold;
  wire abort_en = cfg.reverse_abort_threshold != `SFR_FULL_SCALE;
  wire abort_hit = toward_zero && !in_fast && reverse && abort_en &&
                   tgt_mag > cfg.reverse_abort_threshold;

  wire [9:0] rise_t = sfr_interp(cfg.rise_ms_zero, cfg.rise_ms_top,
                                 frac_use);
  wire [9:0] fall_t = sfr_interp(cfg.fall_ms_zero, cfg.fall_ms_top,
                                 frac_use);
  wire [12:0] rise_eff = sfr_shape(rise_t, cfg.rise_curve_shape,
                                   out_mag);
  wire [12:0] fall_eff = sfr_shape(fall_t, cfg.fall_curve_shape,
                                   out_mag);

  sfr_phase_e phase_nxt;
  logic [12:0] t_act;

  always_comb begin
    phase_nxt = SFR_HOLD;
    t_act = rise_eff;
    if (moving && ramp_on) begin
      if (!toward_zero) begin
        phase_nxt = SFR_RISE;
        t_act = rise_eff;
      end else if (in_fast) begin
        phase_nxt = SFR_FAST;
        t_act = 13'(cfg.fast_fall_ms);
      end else if (abort_r || abort_hit) begin
        phase_nxt = SFR_ABORT;
        t_act = 13'(cfg.abort_fall_ms);
      end else begin
        phase_nxt = SFR_SLOW;
        t_act = fall_eff;
      end
    end
  end

  // credit accumulator: each tick adds full scale, each unit step costs
  // the active time in ms, so full travel takes exactly that many ticks
  wire step_ok = moving && ramp_on && acc_r >= 14'(t_act);
  wire [13:0] acc_left = step_ok ? acc_r - 14'(t_act) : acc_r;
  wire [13:0] acc_nxt = !moving ? 14'h0000 :
                        tick ? acc_left + 14'(`SFR_FULL_SCALE) : acc_left;
  wire signed [11:0] step_dir = (tgt_now > out_s) ? 12'sh001 : -12'sh001;
  wire signed [11:0] out_nxt = !ramp_on ? tgt_now :
                               step_ok ? out_s + step_dir : out_s;
  // set wins: a fresh hit holds the abort even as the old one lapses
  wire abort_nxt = abort_hit ||
                   (abort_r && toward_zero && out_s != 0);

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt_r <= '0;
      tgt_r <= '0;
      req_ready_r <= 1'b0;
      cmd_valid_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      tgt_r <= tgt_now;
      req_ready_r <= fifo_ready;
      cmd_valid_r <= tick;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_flow_r <= '0;
      acc_r <= '0;
      abort_r <= 1'b0;
      phase_r <= SFR_HOLD;
    end else begin
      cmd_flow_r <= sfr_to_flow(out_nxt);
      acc_r <= acc_nxt;
      abort_r <= abort_nxt && ramp_on;
      phase_r <= phase_nxt;
    end
  end

  // zero span means any speed is already at the top of the span
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_r <= '0;
      div_nq_r <= '0;
      div_rem_r <= '0;
      frac_r <= '0;
    end else if (tick && !div_busy) begin
      div_cnt_r <= `SFR_DIV_STEPS;
      div_nq_r <= {speed_clamped, 10'h000};
      div_rem_r <= '0;
    end else if (div_busy) begin
      div_cnt_r <= div_cnt_r - 5'h01;
      div_nq_r <= nq_nxt;
      div_rem_r <= div_ge ? rem_sub : rem_sh;
      if (div_last) begin
        frac_r <= (cfg.speed_span == 10'h000) ? `SFR_FRAC_ONE :
                  nq_nxt[10:0];
      end
    end
  end

endmodule : sfr_ramp_limiter

// ---- tb/sfr_chk.sv ----
// port checker for the flow ramp limiter
`timescale 1ns/10ps
module sfr_chk
  import sfr_pkg::*;
#(
  parameter int TICK_CYCLES = 25000
) (
  input wire logic clk,
  input wire logic srst,
  input wire sfr_cfg_s cfg,
  input wire logic [11:0] vehicle_speed,
  input wire sfr_flow_s req_flow,
  input wire logic req_valid,
  input wire logic req_ready_r,
  input wire sfr_flow_s cmd_flow_r,
  input wire logic cmd_valid_r,
  input wire sfr_phase_e phase_r
);
  int gap_r;
  logic seen_r;
  wire ramping = cfg.ramp_type_select inside {2'h1, 2'h2};
  wire falling = phase_r inside {SFR_FAST, SFR_SLOW, SFR_ABORT};
  // gap only trusted after a first strobe, reset phase is fuzzy
  always_ff @(posedge clk) begin
    gap_r <= (srst || cmd_valid_r) ? 0 : gap_r + 1;
    seen_r <= !srst && (seen_r || cmd_valid_r);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_STEP: assert property (ramping && $past(ramping) |->
    10'(cmd_flow_r.mag - $past(cmd_flow_r.mag)) inside {10'h0, 10'h1, 10'h3ff})
    else $error("set-point stepped more than one unit");
  AST_SIGN: assert property (ramping && $changed(cmd_flow_r.neg) |->
    cmd_flow_r.mag == 10'h0 || $past(cmd_flow_r.mag) == 10'h0)
    else $error("port changed away from zero");
  AST_PULSE: assert property (cmd_valid_r |=> !cmd_valid_r [*8])
    else $error("command strobe too long");
  AST_TICK: assert property (seen_r && cmd_valid_r |->
    gap_r == TICK_CYCLES - 1) else $error("tick period wrong");
  AST_GAP: assert property (seen_r |-> gap_r < TICK_CYCLES)
    else $error("tick missing");
  AST_ONEHOT: assert property ($onehot(phase_r))
    else $error("phase not one-hot");
  AST_FALL: assert property (ramping && falling && $past(falling) &&
    $past(cmd_flow_r.mag) != 10'h0 && $changed(cmd_flow_r.mag) |->
    cmd_flow_r.mag < $past(cmd_flow_r.mag))
    else $error("fall phase moved away from zero");
  AST_RST: assert property (disable iff (1'b0) srst |=>
    cmd_flow_r == '0 && phase_r == SFR_HOLD && !cmd_valid_r && !req_ready_r)
    else $error("reset state wrong");
  AST_READY: assert property ($fell(srst) |-> ##[1:3] req_ready_r)
    else $error("ready not raised after reset");
endmodule : sfr_chk

bind sfr_ramp_limiter sfr_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .clk(clk), .srst(srst), .cfg(cfg), .vehicle_speed(vehicle_speed),
  .req_flow(req_flow), .req_valid(req_valid), .req_ready_r(req_ready_r),
  .cmd_flow_r(cmd_flow_r), .cmd_valid_r(cmd_valid_r), .phase_r(phase_r));

// ---- tb/sfr_spool_model.sv ----
// spool driver model latching each commanded set-point
`timescale 1ns/10ps
module sfr_spool_model
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire sfr_flow_s cmd_flow,
  input wire logic cmd_valid,
  output sfr_flow_s spool_r
);
  // coil only follows on the strobe, between strobes it holds
  always_ff @(posedge clk) begin
    if (srst) begin
      spool_r <= '0;
    end else if (cmd_valid) begin
      spool_r <= cmd_flow;
    end
  end
endmodule : sfr_spool_model

// ---- tb/sfr_ramp_limiter_tb.sv ----
// self-checking bench for the flow ramp limiter
`timescale 1ns/10ps
module sfr_ramp_limiter_tb
  import sfr_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  sfr_cfg_s cfg = '0;
  logic [11:0] vehicle_speed = 12'h0;
  sfr_flow_s req_flow = '0;
  logic req_valid = 1'b0;
  logic req_ready_r, cmd_valid_r;
  sfr_flow_s cmd_flow_r, spool;
  sfr_phase_e phase_r;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [9:0] ath [3] = '{10'h64, 10'h0, 10'h3e8};
  logic [9:0] rev [3] = '{10'hc8, 10'h1, 10'hc8};
  logic [10:0] ph [3] = '{11'h10, 11'h10, 11'h8};

  sfr_ramp_limiter #(.TICK_CYCLES(100)) dut_u (.clk(clk), .srst(srst),
    .cfg(cfg), .vehicle_speed(vehicle_speed), .req_flow(req_flow),
    .req_valid(req_valid), .req_ready_r(req_ready_r),
    .cmd_flow_r(cmd_flow_r), .cmd_valid_r(cmd_valid_r), .phase_r(phase_r));
  sfr_spool_model spool_u (.clk(clk), .srst(srst), .cmd_flow(cmd_flow_r),
    .cmd_valid(cmd_valid_r), .spool_r(spool));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // fast and abort fall times fixed at 10 ms, below every slow fall used
  task automatic cf(input logic [1:0] m, input logic [3:0] sh,
      input logic [9:0] rz, rt, fz, ft, fth, ath_v);
    @(posedge clk);
    cfg <= '{m, sh, sh, rz, fz, rt, ft, 10'h64, fth, 10'ha, ath_v, 10'ha};
  endtask : cf

  task automatic send(input logic n, input logic [9:0] m);
    @(posedge clk);
    req_flow <= '{n, m};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready_r !== 1'b1);
    req_valid <= 1'b0;
  endtask : send

  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff cmd_valid_r);
    #1;
  endtask : ticks

  task automatic chk(input string nm, input logic [10:0] got, lo, hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask : chk

  // mode 0 jump to a level, then hand over to the speed or fixed ramps
  task automatic jump(input logic [9:0] m, input logic [9:0] a);
    cf(2'h0, 4'h0, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h3e8, a);
    send(1'b0, m);
    ticks(2);
    chk("jump", spool, {1'b0, m}, {1'b0, m});
  endtask : jump

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    jump(10'h0, 10'h3e8);
    cf(2'h2, 4'h0, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h3e8, 10'h3e8);
    vehicle_speed <= 12'h32;
    send(1'b0, 10'h3e8);
    ticks(10);
    chk("interp", spool, 11'h1ae, 11'h23a);
    ticks(25);
    chk("top", spool, 11'h3e8, 11'h3e8);
    cf(2'h2, 4'h0, 10'ha, 10'h1e, 10'h14, 10'h28, 10'h3e8, 10'h3e8);
    vehicle_speed <= 12'h384;
    send(1'b0, 10'h0);
    ticks(10);
    chk("clamp", spool, 11'h2bc, 11'h320);
    chk("nofast", {6'h0, phase_r}, 11'h8, 11'h8);
    // fixed mode at top speed must still use the zero-speed rise time
    jump(10'h0, 10'h3e8);
    cf(2'h1, 4'h0, 10'h14, 10'h64, 10'h64, 10'h64, 10'h3e8, 10'h3e8);
    send(1'b0, 10'h3e8);
    ticks(5);
    chk("fixed", spool, 11'hbe, 11'hd2);
    vehicle_speed <= 12'h0;
    jump(10'h3e8, 10'h3e8);
    cf(2'h2, 4'h0, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h1f4, 10'h3e8);
    send(1'b0, 10'h0);
    ticks(2);
    chk("fastph", {6'h0, phase_r}, 11'h4, 11'h4);
    ticks(7);
    chk("fast", spool, 11'h1a4, 11'h1f4);
    jump(10'h0, 10'h3e8);
    cf(2'h2, 4'ha, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h3e8, 10'h3e8);
    send(1'b0, 10'h3e8);
    ticks(2);
    chk("rshape", spool, 11'h1, 11'h3c);
    jump(10'h28, 10'h3e8);
    cf(2'h2, 4'ha, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h3e8, 10'h3e8);
    send(1'b0, 10'h0);
    ticks(3);
    chk("fshape", spool, 11'h1e, 11'h27);
    for (int i = 0; i < 3; i++) begin
      jump(10'h1f4, ath[i]);
      cf(2'h2, 4'h0, 10'ha, 10'h1e, 10'h64, 10'h64, 10'h3e8, ath[i]);
      send(1'b0, 10'h0);
      ticks(2);
      send(1'b1, rev[i]);
      ticks(2);
      chk("abort", {6'h0, phase_r}, ph[i], ph[i]);
      chk("abmag", spool, 11'h0, ph[i][4] ? 11'h190 : 11'h1f4);
    end
    report_and_stop();
  end
endmodule : sfr_ramp_limiter_tb
